// file: logic/efs_status_regs.sv
`timescale 1ns/1ns
module efs_status_regs (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // parallel control port
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    // interrupt pin
    output logic            int_n_o,
    // status_reg_one events (one-cycle pulses)
    input  wire logic       rx_sig_ones_i,
    input  wire logic       rx_distant_mf_alarm_i,
    input  wire logic       rx_sig_zeros_i,
    input  wire logic       rx_slip_i,
    // status_reg_one alarms (levels)
    input  wire logic       rx_unframed_ones_alarm_i,
    input  wire logic       rx_remote_alarm_i,
    input  wire logic       rx_carrier_loss_i,
    input  wire logic       rx_sync_loss_i,
    // status_reg_two and hdlc events (pulses)
    input  wire logic [7:0] status_two_evt_i,
    input  wire logic [7:0] hdlc_status_evt_i,
    // receive_information events (pulses)
    input  wire logic       tx_store_full_i,
    input  wire logic       tx_store_empty_i,
    input  wire logic       jitter_fifo_near_limit_i,
    input  wire logic       rx_store_full_i,
    input  wire logic       rx_store_empty_i,
    input  wire logic       crc_resync_met_i,
    input  wire logic       frame_align_resync_met_i,
    input  wire logic       sig_mf_resync_met_i,
    // synchronizer state
    input  wire logic       frame_align_searching_i,
    input  wire logic       sig_mf_searching_i,
    input  wire logic       crc_mf_searching_i,
    input  wire logic       crc_search_timeout_i,
    input  wire logic       crc_sync_achieved_i,
    input  wire logic       crc_mode_enable_i
);

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    wire sel_sr1  = (addr_i == efs_pkg::OFS_STATUS_ONE);
    wire sel_sr2  = (addr_i == efs_pkg::OFS_STATUS_TWO);
    wire sel_rir  = (addr_i == efs_pkg::OFS_RX_INFO);
    wire sel_irq_mask_one = (addr_i == efs_pkg::OFS_MASK_ONE);
    wire sel_irq_mask_two = (addr_i == efs_pkg::OFS_MASK_TWO);
    wire sel_ssr  = (addr_i == efs_pkg::OFS_SYNC_STATE);
    wire sel_hsr  = (addr_i == efs_pkg::OFS_HDLC_STATUS);
    wire sel_hdlc_irq_mask = (addr_i == efs_pkg::OFS_HDLC_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // source vectors

    logic [7:0] sr1_set;
    logic [7:0] rir_set;

    always_comb begin
        sr1_set = efs_pkg::RST_BYTE;
        sr1_set[efs_pkg::SR1_SIG_ONES]  = rx_sig_ones_i;
        sr1_set[efs_pkg::SR1_DIST_MF]   = rx_distant_mf_alarm_i;
        sr1_set[efs_pkg::SR1_SIG_ZEROS] = rx_sig_zeros_i;
        sr1_set[efs_pkg::SR1_RX_SLIP]   = rx_slip_i;
        sr1_set[efs_pkg::SR1_UNFR_ONES] = rx_unframed_ones_alarm_i;
        sr1_set[efs_pkg::SR1_REMOTE]    = rx_remote_alarm_i;
        sr1_set[efs_pkg::SR1_CARR_LOSS] = rx_carrier_loss_i;
        sr1_set[efs_pkg::SR1_SYNC_LOSS] = rx_sync_loss_i;
    end

    always_comb begin
        rir_set = efs_pkg::RST_BYTE;
        rir_set[efs_pkg::RIR_TX_FULL]    = tx_store_full_i;
        rir_set[efs_pkg::RIR_TX_EMPTY]   = tx_store_empty_i;
        rir_set[efs_pkg::RIR_JIT_LIMIT]  = jitter_fifo_near_limit_i;
        rir_set[efs_pkg::RIR_RX_FULL]    = rx_store_full_i;
        rir_set[efs_pkg::RIR_RX_EMPTY]   = rx_store_empty_i;
        rir_set[efs_pkg::RIR_CRC_RESYNC] = crc_resync_met_i;
        rir_set[efs_pkg::RIR_FAS_RESYNC] = frame_align_resync_met_i;
        rir_set[efs_pkg::RIR_CAS_RESYNC] = sig_mf_resync_met_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // latched status registers

    wire  [7:0] sr1_shown;
    wire  [7:0] sr2_shown;
    wire  [7:0] rir_shown;
    wire  [7:0] hsr_shown;
    wire  [7:0] sr1_irq;
    wire  [7:0] sr2_irq;
    wire  [7:0] hsr_irq;

    // the write-back step of the host sequence is what finally clears the copy
    efs_latch_reg #(
        .ALARM_BITS (efs_pkg::SR1_ALARM_BITS)
    ) u_status_one (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .set_i      (sr1_set),
        .wr_i       (wr_i & sel_sr1),
        .rd_i       (rd_i & sel_sr1),
        .wdata_i    (wdata_i),
        .shown_o    (sr1_shown),
        .irq_src_o  (sr1_irq)
    );

    efs_latch_reg #(
        .ALARM_BITS (efs_pkg::NO_ALARM_BITS)
    ) u_status_two (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .set_i      (status_two_evt_i),
        .wr_i       (wr_i & sel_sr2),
        .rd_i       (rd_i & sel_sr2),
        .wdata_i    (wdata_i),
        .shown_o    (sr2_shown),
        .irq_src_o  (sr2_irq)
    );

    // receive_information has no interrupt path
    efs_latch_reg #(
        .ALARM_BITS (efs_pkg::NO_ALARM_BITS)
    ) u_rx_info (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .set_i      (rir_set),
        .wr_i       (wr_i & sel_rir),
        .rd_i       (rd_i & sel_rir),
        .wdata_i    (wdata_i),
        .shown_o    (rir_shown),
        .irq_src_o  ()
    );

    efs_latch_reg #(
        .ALARM_BITS (efs_pkg::NO_ALARM_BITS)
    ) u_hdlc_status (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .set_i      (hdlc_status_evt_i),
        .wr_i       (wr_i & sel_hsr),
        .rd_i       (rd_i & sel_hsr),
        .wdata_i    (wdata_i),
        .shown_o    (hsr_shown),
        .irq_src_o  (hsr_irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt masks, one means enabled

    logic [7:0] irq_mask_one_reg;
    logic [7:0] irq_mask_two_reg;
    logic [7:0] hdlc_irq_mask_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_mask_one_reg  <= efs_pkg::RST_BYTE;
            irq_mask_two_reg  <= efs_pkg::RST_BYTE;
            hdlc_irq_mask_reg <= efs_pkg::RST_BYTE;
        end else begin
            if (wr_i && sel_irq_mask_one) begin
                irq_mask_one_reg <= wdata_i;
            end
            if (wr_i && sel_irq_mask_two) begin
                irq_mask_two_reg <= wdata_i;
            end
            if (wr_i && sel_hdlc_irq_mask) begin
                hdlc_irq_mask_reg <= wdata_i;
            end
        end
    end

    wire [7:0] sr1_unmasked = sr1_irq & irq_mask_one_reg;
    wire [7:0] sr2_unmasked = sr2_irq & irq_mask_two_reg;
    wire [7:0] hsr_unmasked = hsr_irq & hdlc_irq_mask_reg;
    wire       irq_any      = |{sr1_unmasked, sr2_unmasked, hsr_unmasked};

    logic int_n_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_n_reg <= 1'b1;
        end else begin
            int_n_reg <= ~irq_any;
        end
    end

    assign int_n_o = int_n_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // crc4 sync search counter

    logic [5:0] crc_cnt_reg;
    logic [5:0] crc_cnt_next;

    wire cnt_clear = ~crc_mode_enable_i | crc_sync_achieved_i;
    // plain add keeps the wrap; the host must read often enough to see it
    wire [5:0] cnt_inc = crc_cnt_reg + efs_pkg::CNT_ONE;

    assign crc_cnt_next = cnt_clear            ? efs_pkg::CNT_ZERO :
                          crc_search_timeout_i ? cnt_inc : crc_cnt_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_cnt_reg <= efs_pkg::CNT_ZERO;
        end else begin
            crc_cnt_reg <= crc_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // synchronizer_state, live view

    logic [7:0] ssr_view;

    always_comb begin
        ssr_view = efs_pkg::RST_BYTE;
        ssr_view[efs_pkg::SSR_CNT_HI_MSB:efs_pkg::SSR_CNT_HI_LSB] = crc_cnt_reg[5:2];
        ssr_view[efs_pkg::SSR_CNT_B0]   = crc_cnt_reg[0];
        ssr_view[efs_pkg::SSR_FAS_SRCH] = frame_align_searching_i;
        ssr_view[efs_pkg::SSR_CAS_SRCH] = sig_mf_searching_i;
        ssr_view[efs_pkg::SSR_CRC_SRCH] = crc_mf_searching_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data

    wire [7:0] rd_mux = sel_sr1  ? sr1_shown :
                        sel_sr2  ? sr2_shown :
                        sel_rir  ? rir_shown :
                        sel_irq_mask_one ? irq_mask_one_reg :
                        sel_irq_mask_two ? irq_mask_two_reg :
                        sel_ssr  ? ssr_view :
                        sel_hsr  ? hsr_shown :
                        sel_hdlc_irq_mask ? hdlc_irq_mask_reg : efs_pkg::RST_BYTE;

    logic [7:0] rdata_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= efs_pkg::RST_BYTE;
        end else if (rd_i) begin
            rdata_reg <= rd_mux;
        end
    end

    assign rdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_ssr_live: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && sel_ssr) |=> (rdata_o == {$past(crc_cnt_reg[5:2]), $past(crc_cnt_reg[0]),
            $past(frame_align_searching_i), $past(sig_mf_searching_i),
            $past(crc_mf_searching_i)}))
        else $error("sync state read not live");

    a_cnt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        cnt_clear |=> (crc_cnt_reg == 6'h00))
        else $error("search counter not cleared");

    a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (!cnt_clear && crc_search_timeout_i && crc_cnt_reg != 6'h3f)
        |=> (crc_cnt_reg == $past(crc_cnt_reg) + 6'h01))
        else $error("search counter missed a timeout");

    a_cnt_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (!cnt_clear && crc_search_timeout_i && crc_cnt_reg == 6'h3f)
        |=> (crc_cnt_reg == 6'h00))
        else $error("search counter did not wrap");

    a_irq_low: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_any |=> !int_n_o)
        else $error("interrupt not asserted");

    a_irq_release: assert property (@(posedge clk_i) disable iff (rst_i)
        (!irq_any) |=> int_n_o)
        else $error("interrupt not released");

    a_event_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        (status_two_evt_i[0] && irq_mask_two_reg[0]) |=> ##1 !int_n_o)
        else $error("event interrupt missing");

    ////////////////////////////////////////////////////////////////////////////////
    // mask, read port, counter hold and interrupt source checks
    // these watch the whole byte, not one sample bit, so a stuck lane shows up

    a_mask1_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_i && sel_irq_mask_one) |=> (irq_mask_one_reg == $past(wdata_i)))
        else $error("mask one write lost");

    a_mask2_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_i && sel_irq_mask_two) |=> (irq_mask_two_reg == $past(wdata_i)))
        else $error("mask two write lost");

    a_hmask_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_i && sel_hdlc_irq_mask) |=> (hdlc_irq_mask_reg == $past(wdata_i)))
        else $error("hdlc mask write lost");

    a_mask1_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && sel_irq_mask_one) |=> (rdata_o == $past(irq_mask_one_reg)))
        else $error("mask one read wrong");

    a_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rd_i) |=> $stable(rdata_o))
        else $error("read data moved without a read");

    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && !(sel_sr1 || sel_sr2 || sel_rir || sel_irq_mask_one || sel_irq_mask_two ||
            sel_ssr || sel_hsr || sel_hdlc_irq_mask)) |=> (rdata_o == 8'h00))
        else $error("unmapped read not zero");

    a_all_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        (irq_mask_one_reg == 8'h00 && irq_mask_two_reg == 8'h00 &&
            hdlc_irq_mask_reg == 8'h00) |=> int_n_o)
        else $error("masked source reached the pin");

    a_cnt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!cnt_clear && !crc_search_timeout_i) |=> $stable(crc_cnt_reg))
        else $error("search counter moved without timeout");

    a_alarm_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        (((sr1_set ^ $past(sr1_set)) & efs_pkg::SR1_ALARM_BITS & irq_mask_one_reg) != 8'h00)
        |=> ##1 !int_n_o)
        else $error("alarm change interrupt missing");

    a_sr1_evt_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        ((sr1_set & ~efs_pkg::SR1_ALARM_BITS & irq_mask_one_reg) != 8'h00) |=> ##1 !int_n_o)
        else $error("status one event interrupt missing");

    a_sr2_evt_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        ((status_two_evt_i & irq_mask_two_reg) != 8'h00) |=> ##1 !int_n_o)
        else $error("status two event interrupt missing");

    a_hdlc_evt_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        ((hdlc_status_evt_i & hdlc_irq_mask_reg) != 8'h00) |=> ##1 !int_n_o)
        else $error("hdlc event interrupt missing");

endmodule

// file: logic/efs_pkg.sv
package efs_pkg;

    // register offsets on the parallel port
    localparam logic [7:0] OFS_STATUS_ONE  = 8'h06;
    localparam logic [7:0] OFS_STATUS_TWO  = 8'h07;
    localparam logic [7:0] OFS_RX_INFO     = 8'h08;
    localparam logic [7:0] OFS_MASK_ONE    = 8'h16;
    localparam logic [7:0] OFS_MASK_TWO    = 8'h17;
    localparam logic [7:0] OFS_SYNC_STATE  = 8'h1e;
    localparam logic [7:0] OFS_HDLC_STATUS = 8'h20;
    localparam logic [7:0] OFS_HDLC_MASK   = 8'h21;

    // status_reg_one bit positions
    localparam int SR1_SIG_ONES   = 7;
    localparam int SR1_DIST_MF    = 6;
    localparam int SR1_SIG_ZEROS  = 5;
    localparam int SR1_RX_SLIP    = 4;
    localparam int SR1_UNFR_ONES  = 3;
    localparam int SR1_REMOTE     = 2;
    localparam int SR1_CARR_LOSS  = 1;
    localparam int SR1_SYNC_LOSS  = 0;

    // bits of status_reg_one that follow a persistent alarm level
    localparam logic [7:0] SR1_ALARM_BITS = 8'h0f;
    localparam logic [7:0] NO_ALARM_BITS  = 8'h00;

    // receive_information bit positions
    localparam int RIR_TX_FULL    = 7;
    localparam int RIR_TX_EMPTY   = 6;
    localparam int RIR_JIT_LIMIT  = 5;
    localparam int RIR_RX_FULL    = 4;
    localparam int RIR_RX_EMPTY   = 3;
    localparam int RIR_CRC_RESYNC = 2;
    localparam int RIR_FAS_RESYNC = 1;
    localparam int RIR_CAS_RESYNC = 0;

    // synchronizer_state field positions
    localparam int SSR_CNT_HI_MSB = 7;
    localparam int SSR_CNT_HI_LSB = 4;
    localparam int SSR_CNT_B0     = 3;
    localparam int SSR_FAS_SRCH   = 2;
    localparam int SSR_CAS_SRCH   = 1;
    localparam int SSR_CRC_SRCH   = 0;

    // crc4 sync search counter
    localparam int         CNT_WIDTH = 6;
    localparam logic [5:0] CNT_ZERO  = 6'h00;
    localparam logic [5:0] CNT_ONE   = 6'h01;
    localparam logic [5:0] CNT_MAX   = 6'h3f;

    // reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;

endpackage

// file: logic/efs_latch_reg.sv
`timescale 1ns/1ns
module efs_latch_reg #(
    parameter logic [7:0] ALARM_BITS = 8'h00
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // sources: pulses for events, levels for alarm bits
    input  wire logic [7:0] set_i,
    // port access to this register
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    // readable copy and interrupt sources
    output logic      [7:0] shown_o,
    output logic      [7:0] irq_src_o
);

    logic [7:0] lat_reg;
    logic [7:0] lat_next;
    logic [7:0] shown_reg;
    logic [7:0] shown_next;
    logic [7:0] armed_reg;
    logic [7:0] prev_reg;
    logic [7:0] apend_reg;
    logic [7:0] apend_next;
    wire  [7:0] rd_clr;
    wire  [7:0] alarm_chg;

    // only bits armed by the last mask write are cleared by the read
    assign rd_clr    = rd_i ? armed_reg : efs_pkg::RST_BYTE;
    assign alarm_chg = (set_i ^ prev_reg) & ALARM_BITS;
    // new set wins over the read clear; alarm levels re-set while present
    assign lat_next   = (lat_reg & ~rd_clr) | set_i;
    assign shown_next = wr_i ? ((lat_reg & wdata_i) | (shown_reg & ~wdata_i))
                             : shown_reg;
    assign apend_next = (apend_reg & ~rd_clr) | alarm_chg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lat_reg   <= efs_pkg::RST_BYTE;
            shown_reg <= efs_pkg::RST_BYTE;
            armed_reg <= efs_pkg::RST_BYTE;
            prev_reg  <= efs_pkg::RST_BYTE;
            apend_reg <= efs_pkg::RST_BYTE;
        end else begin
            lat_reg   <= lat_next;
            shown_reg <= shown_next;
            armed_reg <= wr_i ? wdata_i : (rd_i ? efs_pkg::RST_BYTE : armed_reg);
            prev_reg  <= set_i & ALARM_BITS;
            apend_reg <= apend_next;
        end
    end

    assign shown_o = shown_reg;
    // alarms interrupt on change, events while latched
    assign irq_src_o = (apend_reg & ALARM_BITS) | (lat_reg & ~ALARM_BITS);

    a_set_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (set_i != 8'h00) |=> ((lat_reg & $past(set_i)) == $past(set_i)))
        else $error("status bit not latched");
    a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && set_i == 8'h00) |=> ((lat_reg & $past(armed_reg)) == 8'h00))
        else $error("armed bit not cleared by read");
    a_mask_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_i |=> ((shown_reg & ~$past(wdata_i)) == ($past(shown_reg) & ~$past(wdata_i))))
        else $error("unmasked bit changed on write");
    a_mask_update: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_i |=> ((shown_reg & $past(wdata_i)) == ($past(lat_reg) & $past(wdata_i))))
        else $error("masked bit not refreshed");
    a_alarm_change: assert property (@(posedge clk_i) disable iff (rst_i)
        (alarm_chg != 8'h00) |=> ((irq_src_o & $past(alarm_chg)) == $past(alarm_chg)))
        else $error("alarm change raised no interrupt");

endmodule

// file: tb/efs_host_model.sv
`timescale 1ns/1ns
module efs_host_model (
    // clock and read data
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    // parallel port strobes
    output logic      [7:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o
);
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    // one strobe per call, idle cycle between calls keeps strobes single-driven
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
    endtask

    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        d = rdata_i;
    endtask

    // mask, read at once, write back the masked byte so seen bits clear and late changes stay latched
    task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
        put(a, m);
        get(a, d);
        put(a, d & m);
    endtask

    // software gives up after 50 search windows of 8 ms
    function automatic logic overdue(input logic [5:0] windows);
        return windows >= 6'h32;
    endfunction
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic       clk_i;
    logic       rst_i;
    logic [7:0] addr, wdata, rdata;
    logic       wr, rd, int_n;
    logic [7:0] sr1_ev, sr2_ev, hd_ev, rir_ev;
    logic [3:0] alarm;
    logic [2:0] srch;
    logic       tmo, sync_ok, crc_en;
    logic [7:0] ofs_tab [4];
    logic [7:0] msk_tab [4];
    logic [5:0] cnt_exp;
    int         bad_count = 0;
    int         checks_done = 0;

    efs_status_regs dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
        .wdata_i(wdata), .rdata_o(rdata), .int_n_o(int_n),
        .rx_sig_ones_i(sr1_ev[7]), .rx_distant_mf_alarm_i(sr1_ev[6]),
        .rx_sig_zeros_i(sr1_ev[5]), .rx_slip_i(sr1_ev[4]),
        .rx_unframed_ones_alarm_i(alarm[3]), .rx_remote_alarm_i(alarm[2]),
        .rx_carrier_loss_i(alarm[1]), .rx_sync_loss_i(alarm[0]),
        .status_two_evt_i(sr2_ev), .hdlc_status_evt_i(hd_ev),
        .tx_store_full_i(rir_ev[7]), .tx_store_empty_i(rir_ev[6]),
        .jitter_fifo_near_limit_i(rir_ev[5]), .rx_store_full_i(rir_ev[4]),
        .rx_store_empty_i(rir_ev[3]), .crc_resync_met_i(rir_ev[2]),
        .frame_align_resync_met_i(rir_ev[1]), .sig_mf_resync_met_i(rir_ev[0]),
        .frame_align_searching_i(srch[2]), .sig_mf_searching_i(srch[1]),
        .crc_mf_searching_i(srch[0]), .crc_search_timeout_i(tmo),
        .crc_sync_achieved_i(sync_ok), .crc_mode_enable_i(crc_en)
    );

    efs_host_model host (
        .clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata)
    );

    initial clk_i = 1'b0;
    always #5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [7:0] ssr_exp(input logic [5:0] c, input logic [2:0] s);
        return {c[5:2], c[0], s};
    endfunction

    task automatic pulse(input int g, input int b);
        @(negedge clk_i);
        case (g)
            0: sr1_ev[b] = 1'b1;
            1: sr2_ev[b] = 1'b1;
            2: hd_ev[b] = 1'b1;
            default: rir_ev[b] = 1'b1;
        endcase
        @(negedge clk_i);
        sr1_ev = 8'h00;
        sr2_ev = 8'h00;
        hd_ev = 8'h00;
        rir_ev = 8'h00;
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk_i);
            tmo = 1'b1;
            @(negedge clk_i);
            tmo = 1'b0;
        end
        cnt_exp = cnt_exp + 6'(n);
    endtask

    task automatic see_int(input logic exp);
        repeat (3) @(negedge clk_i);
        check("int_n", {7'h00, int_n}, {7'h00, exp});
    endtask

    // event bit: held through an unarmed read, shown once armed, then cleared
    task automatic evt_case(input int g, input int b, input logic en);
        logic [7:0] m;
        logic [7:0] d;
        m = 8'h01 << b;
        if (g < 3) host.put(msk_tab[g], en ? m : 8'h00);
        pulse(g, b);
        see_int(!(en && g < 3));
        host.put(ofs_tab[g], ~m);
        host.get(ofs_tab[g], d);
        check("unarmed bit", d & m, 8'h00);
        host.poll(ofs_tab[g], m, d);
        check("latched bit", d, m);
        host.get(ofs_tab[g], d);
        check("cleared bit", d, 8'h00);
        see_int(1'b1);
        if (g < 3) host.put(msk_tab[g], 8'h00);
    endtask

    // alarm level: interrupt on both edges, bit persists while present
    task automatic alarm_case(input int b);
        logic [7:0] m;
        logic [7:0] d;
        m = 8'h01 << b;
        host.put(efs_pkg::OFS_MASK_ONE, m);
        @(negedge clk_i);
        alarm[b] = 1'b1;
        see_int(1'b0);
        host.poll(efs_pkg::OFS_STATUS_ONE, m, d);
        check("alarm set", d, m);
        host.get(efs_pkg::OFS_STATUS_ONE, d);
        check("alarm persists", d, m);
        see_int(1'b1);
        @(negedge clk_i);
        alarm[b] = 1'b0;
        see_int(1'b0);
        host.poll(efs_pkg::OFS_STATUS_ONE, m, d);
        check("alarm gone", d, m);
        host.put(efs_pkg::OFS_STATUS_ONE, m);
        host.get(efs_pkg::OFS_STATUS_ONE, d);
        check("alarm cleared", d, 8'h00);
        see_int(1'b1);
        host.put(efs_pkg::OFS_MASK_ONE, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        $display("run limit reached");
        test_done();
    end

    initial begin
        logic [7:0] d;
        logic [5:0] n;
        void'($urandom(53231));
        rst_i = 1'b1;
        {sr1_ev, sr2_ev, hd_ev, rir_ev} = 32'h0000_0000;
        alarm = 4'h0;
        srch = 3'h0;
        {tmo, sync_ok, crc_en} = 3'h1;
        cnt_exp = 6'h00;
        ofs_tab = '{efs_pkg::OFS_STATUS_ONE, efs_pkg::OFS_STATUS_TWO,
                    efs_pkg::OFS_HDLC_STATUS, efs_pkg::OFS_RX_INFO};
        msk_tab = '{efs_pkg::OFS_MASK_ONE, efs_pkg::OFS_MASK_TWO,
                    efs_pkg::OFS_HDLC_MASK, efs_pkg::OFS_SYNC_STATE};
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        for (int i = 0; i < 4; i++) begin
            host.get(ofs_tab[i], d);
            check("reset value", d, 8'h00);
            host.get(msk_tab[i], d);
            check("reset value", d, 8'h00);
        end
        host.get(8'h3c, d);
        check("unmapped read", d, 8'h00);
        see_int(1'b1);
        $display("reset test done");
        for (int g = 0; g < 4; g++)
            for (int b = (g == 0) ? 4 : 0; b < 8; b++)
                evt_case(g, b, 1'($urandom % 2));
        $display("event test done");
        for (int b = 0; b < 4; b++)
            alarm_case(b);
        $display("alarm test done");
        // two pending sources: one cleared, the other still holds the pin
        host.put(efs_pkg::OFS_MASK_TWO, 8'h01);
        host.put(efs_pkg::OFS_HDLC_MASK, 8'h01);
        pulse(1, 0);
        pulse(2, 0);
        host.poll(efs_pkg::OFS_STATUS_TWO, 8'h01, d);
        see_int(1'b0);
        host.poll(efs_pkg::OFS_HDLC_STATUS, 8'h01, d);
        see_int(1'b1);
        $display("combine test done");
        for (int k = 0; k < 6; k++) begin
            srch = 3'($urandom);
            tick(1 + $urandom % 9);
            host.get(efs_pkg::OFS_SYNC_STATE, d);
            check("sync state", d, ssr_exp(cnt_exp, srch));
        end
        tick(int'(6'h3f - cnt_exp));
        host.put(efs_pkg::OFS_SYNC_STATE, 8'h00);
        host.get(efs_pkg::OFS_SYNC_STATE, d);
        check("count max", d, ssr_exp(6'h3f, srch));
        tick(1);
        host.get(efs_pkg::OFS_SYNC_STATE, d);
        check("count wrap", d, ssr_exp(6'h00, srch));
        n = 6'(2 + $urandom % 5);
        tick(int'(n));
        @(negedge clk_i);
        sync_ok = 1'b1;
        @(negedge clk_i);
        sync_ok = 1'b0;
        host.get(efs_pkg::OFS_SYNC_STATE, d);
        check("sync clears", d, ssr_exp(6'h00, srch));
        cnt_exp = 6'h00;
        tick(3);
        crc_en = 1'b0;
        tick(2);
        host.get(efs_pkg::OFS_SYNC_STATE, d);
        check("mode off clears", d, ssr_exp(6'h00, srch));
        $display("counter test done");
        check("overdue", {7'h00, host.overdue(6'h32)}, 8'h01);
        check("not overdue", {7'h00, host.overdue(6'h31)}, 8'h00);
        test_done();
    end
endmodule
